// file: stage_sync_defines.vh
/*
 Constants shared by the power stage auxiliary logic: register offsets,
 field positions, reset values, mode codes and vector addresses.
 Assumes it is included by bare name from the design file.
*/
`ifndef STAGE_SYNC_DEFINES_VH
`define STAGE_SYNC_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port).
// ----------------------------------------------------------------------
`define OFS_CTRL0 4'h0
`define OFS_CTRL1 4'h1
`define OFS_CTRL2 4'h2
`define OFS_SYNC2 4'h3
`define OFS_MATRIX 4'h4
`define OFS_CAPT0 4'h5
`define OFS_CAPT1 4'h6
`define OFS_CAPT2 4'h7
`define OFS_RA0 4'h8
`define OFS_RA1 4'h9
`define OFS_RA2 4'ha
`define OFS_RB0 4'hb
`define OFS_RB1 4'hc
`define OFS_RB2 4'hd
`define OFS_STATUS 4'he

// ----------------------------------------------------------------------
// Control register fields (one per stage).
// ----------------------------------------------------------------------
`define CTL_RUN 0
`define CTL_AUTORUN 1
`define CTL_SOFTCAP 2
`define CTL_CLKSEL 3
`define CTL_PRE_LO 4
`define CTL_PRE_HI 5
`define CTL_POL 6
`define CTL_EC_EN 7
`define CTL_CAP_EN 8
`define CTL_FLT_EN 9
`define CTL_MODE_LO 10
`define CTL_MODE_HI 12
`define CTL_CTR_LO 14
`define CTL_CTR_HI 15
`define CTL_W 16
`define CTL_RST 16'h0000

// Synchro and output configuration fields of stage 2.
`define SYN_SEL_LO 4
`define SYN_SEL_HI 5
`define SYN_AUXA 6
`define SYN_AUXB 7
`define SYN_RST 8'h00

// ----------------------------------------------------------------------
// Codes.
// ----------------------------------------------------------------------
`define RUN_ONE 2'h0
`define RUN_TWO 2'h1
`define RUN_FOUR 2'h2
`define RUN_CENTER 2'h3
`define IMODE_HALT 4'h7
`define PRE_1 2'h0
`define PRE_4 2'h1
`define PRE_32 2'h2
`define DIV_4 8'h03
`define DIV_32 8'h1f
`define DIV_256 8'hff
`define CNT_W 12
`define CNT_ZERO 12'h000
`define CNT_ONE 12'h001
`define VEC_W 3
`define VEC_NONE 3'h0
`define VEC_BASE 3'h1

`endif

// file: power_stage_unit.v
/*
 Auxiliary logic of three 12-bit power stage units: counter capture,
 run and halt-fault daisy chain, clock prescaling, ADC strobe, output
 matrix and duplicated outputs of stage 2, and interrupt requests.
 Assumes one 10 MHz clock, a synchronous active-high reset, and a
 register master that never needs wait states. The PLL clock arrives
 as a synchronous tick input.
*/
`timescale 1ns/100ps
`default_nettype none
`include "stage_sync_defines.vh"

module power_stage_unit #(
   parameter NSTAGE = 3
) (
   // Clock and reset.
   input wire REF_CLK,
   input wire SYS_RST,
   // Register port.
   input wire [3:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   // Clock ticks and stage inputs.
   input wire PLL_TICK,
   input wire [NSTAGE-1:0] STAGE_EVENT,
   input wire [NSTAGE-1:0] STAGE_FAULT,
   input wire [NSTAGE-1:0] SYNC_ERROR,
   input wire [NSTAGE-1:0] WAVE_OUT0,
   input wire [NSTAGE-1:0] WAVE_OUT1,
   input wire [1:0] RAMP_INDEX,
   input wire CNT_DOWN,
   // Stage results.
   output wire [NSTAGE-1:0] STAGE_RUN,
   output wire [NSTAGE-1:0] STAGE_PRESCALED_CLOCK,
   output reg [NSTAGE-1:0] END_OF_CYCLE_IRQ,
   output reg [NSTAGE-1:0] CAPTURE_EVENT_IRQ,
   output reg [2:0] IRQ_VECTOR,
   // Stage 2 pins and ADC strobe.
   output reg STAGE2_PRIMARY_OUT0,
   output reg STAGE2_PRIMARY_OUT1,
   output reg STAGE2_AUX_OUT_A,
   output reg STAGE2_AUX_OUT_B,
   output reg ADC_STROBE
);

   reg [`CTL_W-1:0] stage_control_reg [0:NSTAGE-1];
   reg [`CNT_W-1:0] counter [0:NSTAGE-1];
   reg [`CNT_W-1:0] captured_count_reg [0:NSTAGE-1];
   reg [`CNT_W-1:0] reset_a_compare_reg [0:NSTAGE-1];
   reg [`CNT_W-1:0] reset_b_compare_reg [0:NSTAGE-1];
   reg [7:0] stage2_sync_output_cfg;
   reg [3:0] matrix_out0_ramp_bit;
   reg [3:0] matrix_out1_ramp_bit;
   reg [7:0] prescale_cnt [0:NSTAGE-1];
   reg [NSTAGE-1:0] fault_chain;
   reg out0_prev;
   reg out1_prev;
   wire [NSTAGE-1:0] halt_fault;
   wire [NSTAGE-1:0] run_eff;
   wire [NSTAGE-1:0] tick;
   wire [NSTAGE-1:0] ec_hit;
   wire [NSTAGE-1:0] cap_hit;
   wire matrix_on;
   wire [1:0] strobe_sel;
   reg next_out0;
   reg next_out1;
   reg next_strobe;
   integer k;

   assign STAGE_RUN = run_eff;

   // ---------------------------------------------------------------
   // Per-stage logic.
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NSTAGE; g = g + 1)
      begin : stg
         wire [15:0] c = stage_control_reg[g];
         wire own_run = c[`CTL_RUN];
         wire auto = c[`CTL_AUTORUN];
         // An autorun stage runs whenever its predecessor runs. Stage 0 has no
         // predecessor, so the chain cannot close on itself.
         if (g == 0)
         begin : head
            assign run_eff[g] = own_run;
         end
         else
         begin : link
            assign run_eff[g] = own_run | (auto & run_eff[g-1]);
         end
         assign halt_fault[g] = STAGE_FAULT[g] & c[`CTL_FLT_EN]
            & (c[`CTL_MODE_HI:`CTL_MODE_LO] == `IMODE_HALT);
         wire sel_clk = c[`CTL_CLKSEL] ? PLL_TICK : 1'b1;
         wire [7:0] lim = (c[`CTL_PRE_HI:`CTL_PRE_LO] == `PRE_1) ? 8'h00 :
            (c[`CTL_PRE_HI:`CTL_PRE_LO] == `PRE_4) ? `DIV_4 :
            (c[`CTL_PRE_HI:`CTL_PRE_LO] == `PRE_32) ? `DIV_32 : `DIV_256;
         // Comparing with >= recovers at once when the divider is lowered on a
         // running stage, instead of waiting for the count to wrap.
         assign tick[g] = sel_clk & (prescale_cnt[g] >= lim);
         assign STAGE_PRESCALED_CLOCK[g] = tick[g];
         assign ec_hit[g] = run_eff[g] & tick[g]
            & (counter[g] == reset_b_compare_reg[g]);
         assign cap_hit[g] = STAGE_EVENT[g] | c[`CTL_SOFTCAP];

         always @(posedge REF_CLK)
         begin
            if (SYS_RST)
            begin
               prescale_cnt[g] <= 8'h00;
               counter[g] <= `CNT_ZERO;
               captured_count_reg[g] <= `CNT_ZERO;
               END_OF_CYCLE_IRQ[g] <= 1'b0;
               CAPTURE_EVENT_IRQ[g] <= 1'b0;
            end
            else
            begin
               if (!run_eff[g] || fault_chain[g])
                  prescale_cnt[g] <= 8'h00;
               else if (sel_clk)
                  prescale_cnt[g] <= tick[g] ? 8'h00 : prescale_cnt[g] + 8'h01;
               // Stopped stages hold zero so chained stages start aligned.
               if (!run_eff[g] || fault_chain[g])
                  counter[g] <= `CNT_ZERO;
               else if (ec_hit[g])
                  counter[g] <= `CNT_ZERO;
               else if (tick[g])
                  counter[g] <= counter[g] + `CNT_ONE;
               if (cap_hit[g])
                  captured_count_reg[g] <= counter[g];
               END_OF_CYCLE_IRQ[g] <= ec_hit[g] & c[`CTL_EC_EN];
               CAPTURE_EVENT_IRQ[g] <= (cap_hit[g] | SYNC_ERROR[g])
                  & c[`CTL_CAP_EN];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Halt fault chain, both directions between linked neighbours.
   // ---------------------------------------------------------------
   genvar h;
   generate
      for (h = 0; h < NSTAGE; h = h + 1)
      begin : chain
         wire from_prev;
         wire from_next;
         // The end stages have no neighbour on one side, so no index leaves the array.
         if (h == 0)
         begin : first
            assign from_prev = 1'b0;
         end
         else
         begin : mid
            assign from_prev = stage_control_reg[h][`CTL_AUTORUN] & halt_fault[h-1];
         end
         if (h == NSTAGE - 1)
         begin : last
            assign from_next = 1'b0;
         end
         else
         begin : up
            assign from_next = stage_control_reg[h+1][`CTL_AUTORUN] & halt_fault[h+1];
         end
         always @(posedge REF_CLK)
         begin
            if (SYS_RST)
               fault_chain[h] <= 1'b0;
            else
               fault_chain[h] <= halt_fault[h] | from_prev | from_next;
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Stage 2 outputs and ADC strobe.
   // ---------------------------------------------------------------
   assign matrix_on = (stage_control_reg[2][`CTL_CTR_HI:`CTL_CTR_LO] == `RUN_FOUR);
   assign strobe_sel = stage2_sync_output_cfg[`SYN_SEL_HI:`SYN_SEL_LO];

   always @*
   begin
      if (matrix_on)
      begin
         next_out0 = matrix_out0_ramp_bit[RAMP_INDEX];
         next_out1 = matrix_out1_ramp_bit[RAMP_INDEX];
      end
      else
      begin
         next_out0 = WAVE_OUT0[2] ^ stage_control_reg[2][`CTL_POL];
         next_out1 = WAVE_OUT1[2] ^ stage_control_reg[2][`CTL_POL];
      end
      // Centered mode has no usable output edge, so the reset-A match times it.
      if (stage_control_reg[2][`CTL_CTR_HI:`CTL_CTR_LO] == `RUN_CENTER)
         next_strobe = (counter[2] == reset_a_compare_reg[2]) && tick[2]
            && !strobe_sel[1] && (CNT_DOWN == !strobe_sel[0]);
      else
         case (strobe_sel)
            2'h0: next_strobe = WAVE_OUT0[2] & ~out0_prev;
            2'h1: next_strobe = ~WAVE_OUT0[2] & out0_prev;
            2'h2: next_strobe = WAVE_OUT1[2] & ~out1_prev;
            2'h3: next_strobe = ~WAVE_OUT1[2] & out1_prev;
            default: next_strobe = 1'b0;
         endcase
   end

   always @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         STAGE2_PRIMARY_OUT0 <= 1'b0;
         STAGE2_PRIMARY_OUT1 <= 1'b0;
         STAGE2_AUX_OUT_A <= 1'b0;
         STAGE2_AUX_OUT_B <= 1'b0;
         ADC_STROBE <= 1'b0;
         out0_prev <= 1'b0;
         out1_prev <= 1'b0;
      end
      else
      begin
         STAGE2_PRIMARY_OUT0 <= next_out0;
         STAGE2_PRIMARY_OUT1 <= next_out1;
         STAGE2_AUX_OUT_A <= stage2_sync_output_cfg[`SYN_AUXA] ? next_out1
            : next_out0;
         STAGE2_AUX_OUT_B <= stage2_sync_output_cfg[`SYN_AUXB] ? next_out0
            : next_out1;
         ADC_STROBE <= next_strobe;
         out0_prev <= WAVE_OUT0[2];
         out1_prev <= WAVE_OUT1[2];
      end
   end

   // ---------------------------------------------------------------
   // Vector number: stage 2 capture first, stage 0 end-of-cycle last.
   // ---------------------------------------------------------------
   always @(posedge REF_CLK)
   begin
      if (SYS_RST)
         IRQ_VECTOR <= `VEC_NONE;
      else if (CAPTURE_EVENT_IRQ[2])
         IRQ_VECTOR <= `VEC_BASE;
      else if (END_OF_CYCLE_IRQ[2])
         IRQ_VECTOR <= `VEC_BASE + 3'h1;
      else if (CAPTURE_EVENT_IRQ[1])
         IRQ_VECTOR <= `VEC_BASE + 3'h2;
      else if (END_OF_CYCLE_IRQ[1])
         IRQ_VECTOR <= `VEC_BASE + 3'h3;
      else if (CAPTURE_EVENT_IRQ[0])
         IRQ_VECTOR <= `VEC_BASE + 3'h4;
      else if (END_OF_CYCLE_IRQ[0])
         IRQ_VECTOR <= `VEC_BASE + 3'h5;
      else
         IRQ_VECTOR <= `VEC_NONE;
   end

   // ---------------------------------------------------------------
   // Register port. The soft capture bit is a one-cycle pulse.
   // ---------------------------------------------------------------
   always @(posedge REF_CLK)
   begin
      if (SYS_RST)
      begin
         for (k = 0; k < NSTAGE; k = k + 1)
         begin
            stage_control_reg[k] <= `CTL_RST;
            reset_a_compare_reg[k] <= `CNT_ZERO;
            reset_b_compare_reg[k] <= `CNT_ZERO;
         end
         stage2_sync_output_cfg <= `SYN_RST;
         matrix_out0_ramp_bit <= 4'h0;
         matrix_out1_ramp_bit <= 4'h0;
         RDATA <= 16'h0000;
      end
      else
      begin
         for (k = 0; k < NSTAGE; k = k + 1)
         begin
            stage_control_reg[k][`CTL_SOFTCAP] <= 1'b0;
            // A halt fault drops the run bit; software must set it again.
            if (fault_chain[k])
               stage_control_reg[k][`CTL_RUN] <= 1'b0;
         end
         // A write lands after the hardware clears, so software can restart a halted stage.
         if (WR)
            case (ADDR)
               `OFS_CTRL0: stage_control_reg[0] <= WDATA;
               `OFS_CTRL1: stage_control_reg[1] <= WDATA;
               `OFS_CTRL2: stage_control_reg[2] <= WDATA;
               `OFS_SYNC2: stage2_sync_output_cfg <= WDATA[7:0];
               `OFS_MATRIX:
               begin
                  matrix_out0_ramp_bit <= WDATA[3:0];
                  matrix_out1_ramp_bit <= WDATA[7:4];
               end
               `OFS_RA0: reset_a_compare_reg[0] <= WDATA[11:0];
               `OFS_RA1: reset_a_compare_reg[1] <= WDATA[11:0];
               `OFS_RA2: reset_a_compare_reg[2] <= WDATA[11:0];
               `OFS_RB0: reset_b_compare_reg[0] <= WDATA[11:0];
               `OFS_RB1: reset_b_compare_reg[1] <= WDATA[11:0];
               `OFS_RB2: reset_b_compare_reg[2] <= WDATA[11:0];
               default: ;
            endcase
         RDATA <= 16'h0000;
         if (RD)
            case (ADDR)
               `OFS_CTRL0: RDATA <= stage_control_reg[0];
               `OFS_CTRL1: RDATA <= stage_control_reg[1];
               `OFS_CTRL2: RDATA <= stage_control_reg[2];
               `OFS_SYNC2: RDATA <= {8'h00, stage2_sync_output_cfg};
               `OFS_MATRIX: RDATA <= {8'h00, matrix_out1_ramp_bit, matrix_out0_ramp_bit};
               `OFS_CAPT0: RDATA <= {4'h0, captured_count_reg[0]};
               `OFS_CAPT1: RDATA <= {4'h0, captured_count_reg[1]};
               `OFS_CAPT2: RDATA <= {4'h0, captured_count_reg[2]};
               `OFS_RA0: RDATA <= {4'h0, reset_a_compare_reg[0]};
               `OFS_RA1: RDATA <= {4'h0, reset_a_compare_reg[1]};
               `OFS_RA2: RDATA <= {4'h0, reset_a_compare_reg[2]};
               `OFS_RB0: RDATA <= {4'h0, reset_b_compare_reg[0]};
               `OFS_RB1: RDATA <= {4'h0, reset_b_compare_reg[1]};
               `OFS_RB2: RDATA <= {4'h0, reset_b_compare_reg[2]};
               `OFS_STATUS: RDATA <= {10'h000, fault_chain, run_eff};
               default: RDATA <= 16'h0000;
            endcase
      end
   end

endmodule // power_stage_unit
`default_nettype wire

// file: stage_sync_props.sv
/*
 Checker of power_stage_unit: port relations of stage 2 pins, run chain,
 interrupt requests and read data. Assumes one clock and a synchronous
 active-high reset; bound to the design below.
*/
`timescale 1ns/100ps
`default_nettype none
module stage_sync_props #(
   parameter NSTAGE = 3
) (
   // Clock and reset.
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // Register port.
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   // Stage results.
   input wire logic [NSTAGE-1:0] STAGE_RUN,
   input wire logic [NSTAGE-1:0] END_OF_CYCLE_IRQ,
   input wire logic [NSTAGE-1:0] CAPTURE_EVENT_IRQ,
   input wire logic [2:0] IRQ_VECTOR,
   // Stage 2 pins.
   input wire logic STAGE2_PRIMARY_OUT0,
   input wire logic STAGE2_PRIMARY_OUT1,
   input wire logic STAGE2_AUX_OUT_A,
   input wire logic STAGE2_AUX_OUT_B,
   input wire logic ADC_STROBE
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   AST_RESET_QUIET:
   assert property (disable iff (1'b0) SYS_RST |=> IRQ_VECTOR == 3'h0 && ADC_STROBE == 1'b0
      && END_OF_CYCLE_IRQ == '0 && CAPTURE_EVENT_IRQ == '0) else $error("busy after reset");
   AST_RDATA_IDLE:
   assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("read data without read");
   // Equal, settled primaries make the selector invisible, so a one-cycle lag is tolerated.
   AST_AUX_A_COPY:
   assert property (STAGE2_PRIMARY_OUT0 == STAGE2_PRIMARY_OUT1 && $stable(STAGE2_PRIMARY_OUT0)
      && $stable(STAGE2_PRIMARY_OUT1) |-> STAGE2_AUX_OUT_A == STAGE2_PRIMARY_OUT0)
      else $error("aux a not a copy");
   AST_AUX_B_COPY:
   assert property (STAGE2_PRIMARY_OUT0 == STAGE2_PRIMARY_OUT1 && $stable(STAGE2_PRIMARY_OUT0)
      && $stable(STAGE2_PRIMARY_OUT1) |-> STAGE2_AUX_OUT_B == STAGE2_PRIMARY_OUT1)
      else $error("aux b not a copy");
   AST_VEC_FIRST:
   assert property (CAPTURE_EVENT_IRQ[2] |=> IRQ_VECTOR == 3'h1) else $error("vector not 1");
   AST_VEC_LAST:
   assert property (END_OF_CYCLE_IRQ == 3'h1 && CAPTURE_EVENT_IRQ == 3'h0
      |=> IRQ_VECTOR == 3'h6) else $error("vector not 6");
   AST_VEC_CAUSE:
   assert property (IRQ_VECTOR != 3'h0 |-> $past(END_OF_CYCLE_IRQ) != 3'h0
      || $past(CAPTURE_EVENT_IRQ) != 3'h0) else $error("vector without request");
   AST_CHAIN_START:
   assert property ($rose(STAGE_RUN[1]) |-> $past(WR) || $rose(STAGE_RUN[0]))
      else $error("stage 1 started alone");

   cover property (CAPTURE_EVENT_IRQ[2]);
   cover property (ADC_STROBE);
   cover property ($rose(STAGE_RUN[1]) && $rose(STAGE_RUN[0]));
endmodule // stage_sync_props

bind power_stage_unit stage_sync_props #(.NSTAGE(NSTAGE)) i_stage_sync_props (
   .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .WR(WR), .RD(RD), .RDATA(RDATA),
   .STAGE_RUN(STAGE_RUN), .END_OF_CYCLE_IRQ(END_OF_CYCLE_IRQ),
   .CAPTURE_EVENT_IRQ(CAPTURE_EVENT_IRQ), .IRQ_VECTOR(IRQ_VECTOR),
   .STAGE2_PRIMARY_OUT0(STAGE2_PRIMARY_OUT0), .STAGE2_PRIMARY_OUT1(STAGE2_PRIMARY_OUT1),
   .STAGE2_AUX_OUT_A(STAGE2_AUX_OUT_A), .STAGE2_AUX_OUT_B(STAGE2_AUX_OUT_B),
   .ADC_STROBE(ADC_STROBE));
`default_nettype wire

// file: switch_stage_model.sv
/*
 Partner model of the waveform generator and ramp sequencer feeding stage 2.
 Assumes the bench calls its tasks; levels change just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module switch_stage_model (
   // Clock.
   input wire logic clk,
   // Waveform side.
   output logic [2:0] wave0,
   output logic [2:0] wave1,
   output logic [1:0] ramp,
   output logic down
);
   // ------------------------------------------------------------
   // Drivers
   // ------------------------------------------------------------
   initial
   begin
      wave0 = 3'h0;
      wave1 = 3'h0;
      ramp = 2'h0;
      down = 1'b0;
   end
   // The ramp number stands until the next call, as a ramp lasts.
   task automatic set_ramp(input logic [1:0] r);
      @(posedge clk);
      ramp <= r;
   endtask
   task automatic set_wave(input logic a, input logic b);
      @(posedge clk);
      wave0 <= {3{a}};
      wave1 <= {3{b}};
   endtask
   task automatic set_down(input logic d);
      @(posedge clk);
      down <= d;
   endtask
endmodule // switch_stage_model
`default_nettype wire

// file: tb_power_stage_unit.sv
/*
 Testbench of power_stage_unit with the waveform partner model.
 Assumes the register map and field codes of the shared defines.
*/
`timescale 1ns/100ps
`default_nettype none
`include "stage_sync_defines.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_power_stage_unit;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic pll = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [2:0] flt = 3'h0;
   logic [2:0] serr = 3'h0;
   wire [15:0] rdata;
   wire [2:0] w0, w1, run, pck, ec, cap, vec;
   wire [1:0] ramp;
   wire down, o0, o1, aa, ab, adc;
   wire [4:0] mon = {cap[2], vec == 3'h6, ec[0], adc, pck[1]};
   int checked = 0;
   int mismatches = 0;
   int cyc = 0;
   int sh[4] = '{0, 2, 5, 8};
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // A PLL tick on every second cycle keeps the two sources apart.
   always @(posedge clk) pll <= ~pll;

   power_stage_unit i_power_stage_unit (.REF_CLK(clk), .SYS_RST(rst), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .PLL_TICK(pll), .STAGE_EVENT(ev),
      .STAGE_FAULT(flt), .SYNC_ERROR(serr), .WAVE_OUT0(w0), .WAVE_OUT1(w1),
      .RAMP_INDEX(ramp), .CNT_DOWN(down), .STAGE_RUN(run), .STAGE_PRESCALED_CLOCK(pck),
      .END_OF_CYCLE_IRQ(ec), .CAPTURE_EVENT_IRQ(cap), .IRQ_VECTOR(vec),
      .STAGE2_PRIMARY_OUT0(o0), .STAGE2_PRIMARY_OUT1(o1), .STAGE2_AUX_OUT_A(aa),
      .STAGE2_AUX_OUT_B(ab), .ADC_STROBE(adc));
   switch_stage_model i_switch_stage_model (.clk(clk), .wave0(w0), .wave1(w1),
      .ramp(ramp), .down(down));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic cnt(input int s, input int len, output int c);
      c = 0;
      repeat (len)
      begin
         #1;
         c += mon[s];
         @(posedge clk);
      end
   endtask
   task automatic pulse(output int t);
      @(posedge clk);
      ev[2] <= 1'b1;
      t = cyc;
      @(posedge clk);
      ev[2] <= 1'b0;
   endtask
   task automatic test_done;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial
   begin
      logic [15:0] d, a, b;
      logic [7:0] mat;
      logic e0, e1;
      int n, t0, t1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         rd_reg(4'(i), d);
         `CHK("reset value", 16'h0000, d)
      end
      wr_reg(4'hf, 16'hffff);
      rd_reg(4'hf, d);
      `CHK("unmapped", 16'h0000, d)
      for (int k = 0; k < 8; k++)
      begin
         wr_reg(`OFS_CTRL1, 16'(k / 4) << 3 | 16'(k % 4) << 4 | 16'h0001);
         cnt(0, 300, n);
         cnt(0, 512, n);
         `CHK("prescale ticks", (k / 4 ? 256 : 512) >> sh[k % 4], n)
      end
      mat = 8'hc5;
      i_switch_stage_model.set_wave(1'b1, 1'b0);
      wr_reg(`OFS_MATRIX, {8'h00, mat});
      for (int m = 0; m < 2; m++)
      begin
         wr_reg(`OFS_CTRL2, m ? 16'h8041 : 16'h0001);
         for (int s = 0; s < 4; s++)
         begin
            wr_reg(`OFS_SYNC2, 16'(s) << 6);
            for (int r = 0; r < 4; r++)
            begin
               i_switch_stage_model.set_ramp(2'(r));
               repeat (3) @(posedge clk);
               #1;
               e0 = m ? mat[r] : 1'b1;
               e1 = m ? mat[4 + r] : 1'b0;
               `CHK("out0", e0, o0)
               `CHK("out1", e1, o1)
               `CHK("aux a", s[0] ? e1 : e0, aa)
               `CHK("aux b", s[1] ? e0 : e1, ab)
            end
         end
      end
      wr_reg(`OFS_CTRL2, 16'h0001);
      i_switch_stage_model.set_wave(1'b0, 1'b0);
      cnt(1, 4, n);
      for (int c = 0; c < 4; c++)
      begin
         wr_reg(`OFS_SYNC2, 16'(c) << 4);
         for (int s = 0; s < 4; s++)
         begin
            i_switch_stage_model.set_wave(s == 0, s == 2);
            cnt(1, 4, n);
            `CHK("strobe edge", int'(s == c), n)
         end
      end
      wr_reg(`OFS_RA2, 16'h0004);
      wr_reg(`OFS_RB2, 16'h0009);
      wr_reg(`OFS_CTRL2, 16'hc001);
      for (int dn = 0; dn < 2; dn++)
         for (int c = 0; c < 4; c++)
         begin
            i_switch_stage_model.set_down(dn[0]);
            wr_reg(`OFS_SYNC2, 16'(c) << 4);
            cnt(1, 20, n);
            cnt(1, 100, n);
            `CHK("centered strobes", (c == 1 - dn) ? 10 : 0, n)
         end
      wr_reg(`OFS_CTRL2, 16'h0000);
      // Stage 2 never gets autorun, so only stages 0 and 1 form the chain.
      for (int f = 0; f < 2; f++)
      begin
         wr_reg(`OFS_CTRL1, f ? 16'h1e02 : 16'h1c02);
         wr_reg(`OFS_CTRL0, 16'h0001);
         #1;
         `CHK("chained start", 2'h3, run[1:0])
         @(posedge clk);
         flt[1] <= 1'b1;
         repeat (2) @(posedge clk);
         flt[1] <= 1'b0;
         repeat (4) @(posedge clk);
         #1;
         `CHK("halt chain", f ? 2'h0 : 2'h3, run[1:0])
         wr_reg(`OFS_CTRL0, 16'h0001);
         wr_reg(`OFS_CTRL0, 16'h0000);
         #1;
         `CHK("chained stop", 2'h0, run[1:0])
      end
      wr_reg(`OFS_CTRL1, 16'h0000);
      wr_reg(`OFS_RB0, 16'h0009);
      for (int e = 1; e >= 0; e--)
      begin
         wr_reg(`OFS_CTRL0, e ? 16'h0081 : 16'h0001);
         cnt(2, 20, n);
         cnt(2, 100, n);
         `CHK("end of cycle", e * 10, n)
         cnt(3, 100, n);
         `CHK("vector six", e * 10, n)
      end
      wr_reg(`OFS_CTRL0, 16'h0000);
      wr_reg(`OFS_RB2, 16'h0fff);
      wr_reg(`OFS_CTRL2, 16'h0101);
      pulse(t0);
      cnt(4, 4, n);
      `CHK("capture irq", 1, n)
      rd_reg(`OFS_CAPT2, a);
      pulse(t1);
      rd_reg(`OFS_CAPT2, b);
      `CHK("capture spacing", 16'(t1 - t0), b - a)
      wr_reg(`OFS_CTRL2, 16'h0105);
      rd_reg(`OFS_CAPT2, d);
      `CHK("soft capture", 1'b1, d != b)
      @(posedge clk);
      serr[2] <= 1'b1;
      @(posedge clk);
      serr[2] <= 1'b0;
      cnt(4, 4, n);
      `CHK("sync error irq", 1, n)
      test_done();
   end
endmodule // tb_power_stage_unit
`default_nettype wire
